// ===== hae_alarm_eval.sv
// heater alarm evaluator: deterioration, last-change-rate and burnout
// alarms per channel, latched, with register port and one interrupt
// assumes all inputs synchronous to clk and meas_tick one cycle per period
`timescale 1ns/100ps
`default_nettype none
module hae_alarm_eval #(
  parameter int N = 4,
  parameter int MA = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic meas_tick,
  input wire logic [N-1:0][hae_pkg::VAL_W-1:0] ref_rate,
  input wire logic [N-1:0][hae_pkg::VAL_W-1:0] resistance,
  input wire logic [N-1:0][hae_pkg::VAL_W-1:0] volt_pct,
  input wire logic [N-1:0][hae_pkg::VAL_W-1:0] curr_pct,
  input wire logic [N-1:0] stabilized_indicator,
  input wire logic [N-1:0] stabilized_indicator_waiting,
  input wire logic [N-1:0] ref_registered,
  input wire logic [N-1:0] sample_ok,
  input wire logic [N-1:0] volt_oor,
  input wire logic [N-1:0] curr_oor,
  input wire logic [hae_pkg::ADDR_W-1:0] addr,
  input wire logic [hae_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [hae_pkg::DATA_W-1:0] rdata,
  output logic irq,
  output logic alarm_warn,
  output logic alarm_crit
);
  import hae_pkg::*;

  localparam int CH_W = (N > 1) ? $clog2(N) : 1;
  localparam int CNT_W = $clog2(MA + 1);
  localparam logic [CNT_W-1:0] OK_FULL = CNT_W'(MA);

  typedef struct packed {
    hae_state_e st;
    logic [CH_W-1:0] ch;
    logic [4:0] bit_cnt;
    logic [NUM_W-1:0] num;
    logic [VAL_W:0] rem;
    logic [VAL_W-1:0] dvs;
    logic [N-1:0][VAL_W-1:0] cur;
    logic [N-1:0][VAL_W-1:0] old;
    logic [N-1:0] pend;
    logic [N-1:0][MA-1:0][VAL_W-1:0] hist_res;
    logic [N-1:0][MA-1:0] hist_stabilized_indicator;
    logic [N-1:0][CNT_W-1:0] ok_run;
    logic [N-1:0][VAL_W-1:0] th_warn;
    logic [N-1:0][VAL_W-1:0] th_crit;
    logic [N-1:0][VAL_W-1:0] th_last;
    logic [N-1:0][VAL_W-1:0] th_volt;
    logic [N-1:0][VAL_W-1:0] th_curr;
    logic [N-1:0][VAL_W-1:0] rate;
    logic [N-1:0][ALM_W-1:0] alarm;
    logic [ALM_W*N-1:0] irq_stat;
    logic [ALM_W*N-1:0] irq_mask;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic lvl_warn;
    logic lvl_crit;
  } hae_reg_s;

  hae_reg_s q;
  hae_reg_s next_q;

  assign rdata = q.rdata;
  assign irq = q.irq;
  assign alarm_warn = q.lvl_warn;
  assign alarm_crit = q.lvl_crit;

  // all next-state logic; tick, divider walk and register port merge here
  always_comb begin
    logic [N-1:0][ALM_W-1:0] set;
    logic [N-1:0][ALM_W-1:0] all_alm;
    logic [ALM_W*N-1:0] flat_set;
    logic [ALM_W*N-1:0] flat_old;
    logic cancel;
    logic tick_go;
    logic in_ch;
    logic [7:0] ch_ofs;
    logic [2:0] fld;
    logic [CH_W-1:0] chi;
    logic [VAL_W:0] r;
    logic [NUM_W-1:0] n;
    logic [VAL_W-1:0] quo;
    logic [DATA_W-1:0] rd_val;
    logic last_ch;
    next_q = q;
    set = '0;
    all_alm = '0;
    flat_set = '0;
    flat_old = '0;
    cancel = 1'b0;
    tick_go = meas_tick && (q.st == HAE_IDLE);
    ch_ofs = addr - OFS_CH_BASE;
    fld = ch_ofs[4:2];
    chi = CH_W'(ch_ofs >> CH_STRIDE_SH);
    in_ch = (addr >= OFS_CH_BASE) && (addr[1:0] == 2'b00) &&
            (32'(ch_ofs >> CH_STRIDE_SH) < N) && (fld <= FLD_LAST_RATE);
    r = '0;
    n = '0;
    quo = '0;
    rd_val = '0;
    last_ch = (32'(q.ch) == N - 1);

    // one evaluation pass per measurement tick, ticks while busy are dropped
    if (tick_go) begin
      for (int c = 0; c < N; c++) begin
        // deterioration only when stabilized and reference registered
        if (stabilized_indicator[c] && ref_registered[c]) begin
          if (ref_rate[c] > q.th_warn[c]) set[c][ALM_DET_WARN] = 1'b1;
          if (ref_rate[c] > q.th_crit[c]) set[c][ALM_DET_CRIT] = 1'b1;
        end
        // burnout suppressed on either out-of-range error
        if (!volt_oor[c] && !curr_oor[c] &&
            volt_pct[c] >= q.th_volt[c] &&
            curr_pct[c] <= q.th_curr[c]) begin
          set[c][ALM_BURN] = 1'b1;
        end
        // all three sample-validity conditions gate the rate division
        next_q.pend[c] = q.hist_stabilized_indicator[c][MA-1] &&
                         sample_ok[c] && q.ok_run[c] >= OK_FULL &&
                         (stabilized_indicator[c] || stabilized_indicator_waiting[c]) &&
                         q.hist_res[c][MA-1] != '0;
        next_q.cur[c] = resistance[c];
        next_q.old[c] = q.hist_res[c][MA-1];
        // older sample is MA ticks back, hence the alarm latency
        next_q.hist_res[c] = {q.hist_res[c][MA-2:0], resistance[c]};
        next_q.hist_stabilized_indicator[c] = {q.hist_stabilized_indicator[c][MA-2:0],
                               stabilized_indicator[c] && sample_ok[c]};
        if (!sample_ok[c]) next_q.ok_run[c] = '0;
        else if (q.ok_run[c] != OK_FULL) next_q.ok_run[c] = q.ok_run[c] + 1'b1;
      end
      next_q.ch = '0;
      next_q.st = HAE_LOAD;
    end

    // serial divider shared by all channels to keep area small
    case (q.st)
      HAE_IDLE: begin
      end
      HAE_LOAD: begin
        if (q.pend[q.ch] && q.cur[q.ch] > q.old[q.ch]) begin
          next_q.num = NUM_W'(q.cur[q.ch] - q.old[q.ch]) * NUM_W'(RATE_SCALE);
          next_q.dvs = q.old[q.ch];
          next_q.rem = '0;
          next_q.bit_cnt = 5'(NUM_W - 1);
          next_q.st = HAE_DIV;
        end else begin
          if (q.pend[q.ch]) next_q.rate[q.ch] = '0; // no rise, no rate
          next_q.pend[q.ch] = 1'b0;
          next_q.ch = q.ch + 1'b1;
          if (last_ch) next_q.st = HAE_IDLE;
        end
      end
      HAE_DIV: begin
        r = {q.rem[VAL_W-1:0], q.num[NUM_W-1]};
        n = {q.num[NUM_W-2:0], 1'b0};
        if (r >= {1'b0, q.dvs}) begin
          r = r - {1'b0, q.dvs};
          n[0] = 1'b1;
        end
        next_q.rem = r;
        next_q.num = n;
        next_q.bit_cnt = q.bit_cnt - 1'b1;
        if (q.bit_cnt == 5'h00) next_q.st = HAE_DONE;
      end
      HAE_DONE: begin
        quo = (q.num[NUM_W-1:VAL_W] != '0) ? RATE_SAT : q.num[VAL_W-1:0];
        next_q.rate[q.ch] = quo;
        if (quo > q.th_last[q.ch]) set[q.ch][ALM_LAST] = 1'b1;
        next_q.pend[q.ch] = 1'b0;
        next_q.ch = q.ch + 1'b1;
        next_q.st = last_ch ? HAE_IDLE : HAE_LOAD;
      end
      default: next_q.st = HAE_IDLE;
    endcase

    // register writes
    if (wr) begin
      if (addr == OFS_CTRL) cancel = wdata[CTRL_CANCEL_BIT];
      if (addr == OFS_IRQ_MASK) next_q.irq_mask = wdata[ALM_W*N-1:0];
      if (in_ch) begin
        case (fld)
          FLD_DET_WARN: next_q.th_warn[chi] = wdata[VAL_W-1:0];
          FLD_DET_CRIT: next_q.th_crit[chi] = wdata[VAL_W-1:0];
          FLD_LAST_TH: next_q.th_last[chi] = wdata[VAL_W-1:0];
          FLD_BURN_VOLT: next_q.th_volt[chi] = wdata[VAL_W-1:0];
          FLD_BURN_CURR: next_q.th_curr[chi] = wdata[VAL_W-1:0];
          default: begin
          end
        endcase
      end
    end

    // latch: cancel clears, a set in the same cycle still wins
    for (int c = 0; c < N; c++) begin
      all_alm[c] = (q.alarm[c] & {ALM_W{~cancel}}) | set[c];
      flat_set[c*ALM_W +: ALM_W] = set[c] & ~q.alarm[c];
      flat_old[c*ALM_W +: ALM_W] = all_alm[c];
    end
    next_q.alarm = all_alm;

    // register reads, data valid in the following cycle only
    if (rd) begin
      if (addr == OFS_CTRL) rd_val = DATA_W'(q.st != HAE_IDLE);
      else if (addr == OFS_ALARM) rd_val = DATA_W'(q.alarm);
      else if (addr == OFS_IRQ_STAT) rd_val = DATA_W'(q.irq_stat);
      else if (addr == OFS_IRQ_MASK) rd_val = DATA_W'(q.irq_mask);
      else if (addr == OFS_LEVEL) rd_val = DATA_W'({q.lvl_crit, q.lvl_warn});
      else if (in_ch) begin
        case (fld)
          FLD_DET_WARN: rd_val = DATA_W'(q.th_warn[chi]);
          FLD_DET_CRIT: rd_val = DATA_W'(q.th_crit[chi]);
          FLD_LAST_TH: rd_val = DATA_W'(q.th_last[chi]);
          FLD_BURN_VOLT: rd_val = DATA_W'(q.th_volt[chi]);
          FLD_BURN_CURR: rd_val = DATA_W'(q.th_curr[chi]);
          FLD_LAST_RATE: rd_val = DATA_W'(q.rate[chi]);
          default: rd_val = '0;
        endcase
      end
    end
    next_q.rdata = rd_val;

    // sticky events, read clears, new event wins over the clear
    next_q.irq_stat = q.irq_stat | flat_set;
    if (rd && addr == OFS_IRQ_STAT) next_q.irq_stat = flat_set;
    next_q.irq = |(next_q.irq_stat & next_q.irq_mask);

    // output levels summarise latched alarms by severity
    next_q.lvl_warn = 1'b0;
    next_q.lvl_crit = 1'b0;
    for (int c = 0; c < N; c++) begin
      if (flat_old[c*ALM_W + ALM_DET_WARN] || flat_old[c*ALM_W + ALM_LAST])
        next_q.lvl_warn = 1'b1;
      if (flat_old[c*ALM_W + ALM_DET_CRIT] || flat_old[c*ALM_W + ALM_BURN])
        next_q.lvl_crit = 1'b1;
    end
  end

  // single state register; reset is the power-on clear of all latches
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.th_warn <= {N{RST_DET_WARN}};
      q.th_crit <= {N{RST_DET_CRIT}};
      q.th_last <= {N{RST_LAST_TH}};
      q.th_volt <= {N{RST_BURN_VOLT}};
      q.th_curr <= {N{RST_BURN_CURR}};
    end else begin
      q <= next_q;
    end
  end

  // checks on channel 0 stand for all channels, the loop is uniform
  wire tick_idle = meas_tick && (q.st == HAE_IDLE);
  wire cancel_wr = wr && addr == OFS_CTRL && wdata[CTRL_CANCEL_BIT];
  // walk bound: every channel may need load, full division and done
  localparam int WALK_MAX = N * (NUM_W + 2) + 4;
  localparam logic [ADDR_W-1:0] RATE0_ADR =
    OFS_CH_BASE | {3'h0, FLD_LAST_RATE, 2'b00};

  a_latch_holds: assert property (@(posedge clk) disable iff (sys_rst)
    !cancel_wr |=> (($past(q.alarm) & ~q.alarm) == '0))
    else $error("alarm dropped without cancel");

  a_cancel_clears: assert property (@(posedge clk) disable iff (sys_rst)
    (cancel_wr && !tick_idle && q.st != HAE_DONE) |=> q.alarm == '0)
    else $error("cancel did not clear alarms");

  a_det_warn_set: assert property (@(posedge clk) disable iff (sys_rst)
    (tick_idle && stabilized_indicator[0] && ref_registered[0] &&
     ref_rate[0] > q.th_warn[0]) |=> q.alarm[0][ALM_DET_WARN] ##1 alarm_warn)
    else $error("warning deterioration not raised");

  a_det_crit_set: assert property (@(posedge clk) disable iff (sys_rst)
    (tick_idle && stabilized_indicator[0] && ref_registered[0] &&
     ref_rate[0] > q.th_crit[0]) |=> q.alarm[0][ALM_DET_CRIT] ##1 alarm_crit)
    else $error("critical deterioration not raised");

  a_det_wait_skip: assert property (@(posedge clk) disable iff (sys_rst)
    (tick_idle && !stabilized_indicator[0] &&
     !q.alarm[0][ALM_DET_WARN]) |=> !q.alarm[0][ALM_DET_WARN])
    else $error("deterioration judged while waiting");

  a_det_unreg_skip: assert property (@(posedge clk) disable iff (sys_rst)
    (tick_idle && !ref_registered[0] &&
     !q.alarm[0][ALM_DET_CRIT]) |=> !q.alarm[0][ALM_DET_CRIT])
    else $error("deterioration judged without reference");

  a_burn_oor_skip: assert property (@(posedge clk) disable iff (sys_rst)
    (tick_idle && (volt_oor[0] || curr_oor[0]) &&
     !q.alarm[0][ALM_BURN]) |=> !q.alarm[0][ALM_BURN])
    else $error("burnout judged during range error");

  a_burn_set: assert property (@(posedge clk) disable iff (sys_rst)
    (tick_idle && !volt_oor[0] && !curr_oor[0] &&
     volt_pct[0] >= q.th_volt[0] && curr_pct[0] <= q.th_curr[0])
    |=> q.alarm[0][ALM_BURN] ##1 alarm_crit)
    else $error("burnout not raised");

  a_last_invalid: assert property (@(posedge clk) disable iff (sys_rst)
    (tick_idle && !(stabilized_indicator[0] || stabilized_indicator_waiting[0]))
    |=> !q.pend[0])
    else $error("last rate judged on invalid sample");

  a_div_bound: assert property (@(posedge clk) disable iff (sys_rst)
    (q.st == HAE_DIV && $past(q.st) == HAE_LOAD)
    |-> ##[25:26] q.st == HAE_DONE)
    else $error("division overran");

  a_walk_ends: assert property (@(posedge clk) disable iff (sys_rst)
    tick_idle |-> ##[1:WALK_MAX] q.st == HAE_IDLE)
    else $error("evaluation walk overran");

  a_old_unstab: assert property (@(posedge clk) disable iff (sys_rst)
    (tick_idle && !q.hist_stabilized_indicator[0][MA-1]) |=> !q.pend[0])
    else $error("last rate judged on unstable old sample");

  a_gap_unok: assert property (@(posedge clk) disable iff (sys_rst)
    (tick_idle && (!sample_ok[0] || q.ok_run[0] != OK_FULL))
    |=> !q.pend[0])
    else $error("last rate judged across a failed sample");

  a_rate_alarm: assert property (@(posedge clk) disable iff (sys_rst)
    (q.st == HAE_DONE && q.ch == '0 && q.num[NUM_W-1:VAL_W] == '0 &&
     q.num[VAL_W-1:0] > q.th_last[0]) |=> q.alarm[0][ALM_LAST])
    else $error("last rate alarm not raised");

  a_rate_no_rise: assert property (@(posedge clk) disable iff (sys_rst)
    (q.st == HAE_LOAD && q.ch == '0 && q.pend[0] &&
     q.cur[0] <= q.old[0]) |=> q.rate[0] == '0)
    else $error("rate kept without a rise");

  a_rate_readout: assert property (@(posedge clk) disable iff (sys_rst)
    (rd && addr == RATE0_ADR) |=> rdata[VAL_W-1:0] == $past(q.rate[0]))
    else $error("last rate not readable on the port");

  a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !rd |=> rdata == '0)
    else $error("read data stood without a read");

  a_warn_level: assert property (@(posedge clk) disable iff (sys_rst)
    (q.alarm[0][ALM_DET_WARN] || q.alarm[0][ALM_LAST]) |-> alarm_warn)
    else $error("warning level missing");

  a_crit_level: assert property (@(posedge clk) disable iff (sys_rst)
    (q.alarm[0][ALM_DET_CRIT] || q.alarm[0][ALM_BURN]) |-> alarm_crit)
    else $error("critical level missing");

  a_cancel_levels: assert property (@(posedge clk) disable iff (sys_rst)
    (cancel_wr && !tick_idle && q.st != HAE_DONE)
    |=> !alarm_warn && !alarm_crit)
    else $error("levels stood after cancel");

  a_burn_curr_high: assert property (@(posedge clk) disable iff (sys_rst)
    (tick_idle && curr_pct[0] > q.th_curr[0] &&
     !q.alarm[0][ALM_BURN]) |=> !q.alarm[0][ALM_BURN])
    else $error("burnout raised with current flowing");

  c_det_warn: cover property (@(posedge clk) disable iff (sys_rst)
    !q.alarm[0][ALM_DET_WARN] ##1 q.alarm[0][ALM_DET_WARN]);
  c_last_rate: cover property (@(posedge clk) disable iff (sys_rst)
    !q.alarm[0][ALM_LAST] ##1 q.alarm[0][ALM_LAST]);
  c_burnout: cover property (@(posedge clk) disable iff (sys_rst)
    !q.alarm[0][ALM_BURN] ##1 q.alarm[0][ALM_BURN]);
  c_cancel: cover property (@(posedge clk) disable iff (sys_rst)
    (q.alarm != '0) ##1 (q.alarm == '0));
  c_walk_div: cover property (@(posedge clk) disable iff (sys_rst)
    q.st == HAE_LOAD ##1 q.st == HAE_DIV);

endmodule
`default_nettype wire

// ===== hae_host.sv
// host model: register-port master of the alarm evaluator
// assumes one clock; read data stand only in the cycle after rd
`timescale 1ns/100ps
`default_nettype none
module hae_host (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [31:0] rdata
);
  // bus idle from time zero
  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end

  // one-cycle write strobe, the slave never stalls
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d; // stale data must not look valid
  endtask

  // data taken in the only cycle it stands
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule
`default_nettype wire

// ===== hae_pkg.sv
// constants, register map and state types of the heater alarm evaluator
// assumes one 100 MHz clock and a measurement tick from the sampler
//
// Operation
// - deterioration alarm when reference change rate exceeds its threshold
// - separate warning (3%) and critical (5%) thresholds per channel
// - deterioration judged only while stabilized, skipped while waiting
// - deterioration not judged before the reference value is registered
// - alarms latch until latch-cancel command or power-on reset
// - warning threshold gives warning level, critical gives critical level
// - last-change-rate alarm at warning level above threshold, default 25%
// - older comparison sample must have been taken while stabilized
// - every sample from older to current must be computed successfully
// - current sample must be stabilized or waiting for stabilization
// - last-change-rate judged only when all three conditions hold
// - last change rate readable only through the register port
// - latency to last-change-rate alarm is about depth times tick period
// - burnout from voltage and current, reported at critical level
// - burnout not judged during voltage or current out-of-range error
// - burnout when voltage at least 40% and current at most 1%
package hae_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int VAL_W = 16;
  localparam int ALM_W = 4;

  // global registers (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ALARM = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_LEVEL = 8'h10;
  // per-channel block: base + channel * stride + field * 4
  localparam logic [7:0] OFS_CH_BASE = 8'h40;
  localparam int CH_STRIDE_SH = 5;
  localparam logic [2:0] FLD_DET_WARN = 3'h0;
  localparam logic [2:0] FLD_DET_CRIT = 3'h1;
  localparam logic [2:0] FLD_LAST_TH = 3'h2;
  localparam logic [2:0] FLD_BURN_VOLT = 3'h3;
  localparam logic [2:0] FLD_BURN_CURR = 3'h4;
  localparam logic [2:0] FLD_LAST_RATE = 3'h5;

  // control and alarm field positions
  localparam int CTRL_CANCEL_BIT = 0;
  localparam int ALM_DET_WARN = 0;
  localparam int ALM_DET_CRIT = 1;
  localparam int ALM_LAST = 2;
  localparam int ALM_BURN = 3;
  localparam int LVL_WARN_BIT = 0;
  localparam int LVL_CRIT_BIT = 1;

  // thresholds in units of 0.1 percent
  localparam logic [15:0] RST_DET_WARN = 16'h001E; // 3.0 %
  localparam logic [15:0] RST_DET_CRIT = 16'h0032; // 5.0 %
  localparam logic [15:0] RST_LAST_TH = 16'h00FA; // 25.0 %
  localparam logic [15:0] RST_BURN_VOLT = 16'h0190; // 40.0 %
  localparam logic [15:0] RST_BURN_CURR = 16'h000A; // 1.0 %
  localparam int RATE_SCALE = 1000; // 100 % = 1000 counts
  localparam logic [15:0] RATE_SAT = 16'hFFFF;

  // divider geometry: 16-bit difference times 1000 fits 26 bits
  localparam int NUM_W = 26;

  typedef enum logic [1:0] {
    HAE_IDLE,
    HAE_LOAD,
    HAE_DIV,
    HAE_DONE
  } hae_state_e;

endpackage

// ===== test_heater_alarm_evaluator.sv
// self-checking bench of the heater alarm evaluator, channel 0 exercised
// assumes hae_pkg compiled first and the host model in hae_host
`timescale 1ns/100ps
`default_nettype none
module test_heater_alarm_evaluator;
  import hae_pkg::*;
  localparam int NCH = 4;
  // flag sets {coor,voor,ok,registered,waiting,stabilized}
  localparam logic [5:0] FS = 6'h0D;
  localparam logic [5:0] FW = 6'h0E;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic meas_tick = 1'b0;
  logic [NCH-1:0][VAL_W-1:0] ref_rate = '0, resistance = '0;
  logic [NCH-1:0][VAL_W-1:0] volt_pct = '0, curr_pct = '0;
  logic [NCH-1:0] stabilized_indicator = '0, stabilized_indicator_waiting = '0;
  logic [NCH-1:0] ref_registered = '0, sample_ok = '0;
  logic [NCH-1:0] volt_oor = '0, curr_oor = '0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic wr, rd, irq, alarm_warn, alarm_crit;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  hae_alarm_eval #(.N(NCH), .MA(2)) i_hae_alarm_eval (
    .clk(clk), .sys_rst(sys_rst), .meas_tick(meas_tick),
    .ref_rate(ref_rate), .resistance(resistance), .volt_pct(volt_pct),
    .curr_pct(curr_pct), .stabilized_indicator(stabilized_indicator),
    .stabilized_indicator_waiting(stabilized_indicator_waiting), .ref_registered(ref_registered),
    .sample_ok(sample_ok), .volt_oor(volt_oor), .curr_oor(curr_oor),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq), .alarm_warn(alarm_warn), .alarm_crit(alarm_crit));

  hae_host i_hae_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));

  task automatic complete_run();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_hae_host.bus_read(a, d);
    check(d, exp);
  endtask

  // warn, crit, irq in one compare
  task automatic chk_out(input logic w, input logic c, input logic i);
    check({29'h0, alarm_warn, alarm_crit, irq}, {29'h0, w, c, i});
  endtask

  function automatic logic [7:0] fa(input int ch, input logic [2:0] fld);
    return OFS_CH_BASE + 8'(ch << CH_STRIDE_SH) + {3'h0, fld, 2'b00};
  endfunction

  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  task automatic cancel();
    i_hae_host.bus_write(OFS_CTRL, 32'h1);
    repeat (2) @(posedge clk);
  endtask

  // one measurement pass on channel 0; gap keeps the serial walk idle
  task automatic tk(input logic [15:0] rr, res, v, c, input logic [5:0] f);
    @(posedge clk);
    ref_rate[0] <= rr;
    resistance[0] <= res;
    volt_pct[0] <= v;
    curr_pct[0] <= c;
    {curr_oor[0], volt_oor[0], sample_ok[0]} <= f[5:3];
    {ref_registered[0], stabilized_indicator_waiting[0], stabilized_indicator[0]} <= f[2:0];
    @(posedge clk);
    meas_tick <= 1'b1;
    @(posedge clk);
    meas_tick <= 1'b0;
    repeat (NCH * 30) @(posedge clk);
  endtask

  task automatic t_regs();
    expect_reg(fa(0, FLD_DET_WARN), {16'h0, RST_DET_WARN});
    expect_reg(fa(0, FLD_DET_CRIT), {16'h0, RST_DET_CRIT});
    expect_reg(fa(0, FLD_LAST_TH), {16'h0, RST_LAST_TH});
    expect_reg(fa(0, FLD_BURN_VOLT), {16'h0, RST_BURN_VOLT});
    expect_reg(fa(0, FLD_BURN_CURR), {16'h0, RST_BURN_CURR});
    i_hae_host.bus_write(fa(1, FLD_DET_WARN), 32'hFFFF_0014);
    expect_reg(fa(1, FLD_DET_WARN), 32'h0000_0014);
    expect_reg(fa(0, FLD_DET_WARN), {16'h0, RST_DET_WARN});
    expect_reg(8'h14, 32'h0);
    expect_reg(OFS_ALARM, 32'h0);
    expect_reg(OFS_CTRL, 32'h0);
  endtask

  task automatic t_det();
    tk(16'h003C, 16'h0, 16'h0, 16'h0, FW);
    expect_reg(OFS_ALARM, 32'h0);
    tk(16'h003C, 16'h0, 16'h0, 16'h0, 6'h09);
    expect_reg(OFS_ALARM, 32'h0);
    tk(16'h001E, 16'h0, 16'h0, 16'h0, FS);
    expect_reg(OFS_ALARM, 32'h0);
    tk(16'h001F, 16'h0, 16'h0, 16'h0, FS);
    expect_reg(OFS_ALARM, 32'h1);
    chk_out(1'b1, 1'b0, 1'b0);
    tk(16'h0033, 16'h0, 16'h0, 16'h0, FS);
    expect_reg(OFS_ALARM, 32'h3);
    chk_out(1'b1, 1'b1, 1'b0);
    expect_reg(OFS_LEVEL, 32'h3);
    tk(16'h0, 16'h0, 16'h0, 16'h0, FS);
    expect_reg(OFS_ALARM, 32'h3);
    cancel();
    expect_reg(OFS_ALARM, 32'h0);
    chk_out(1'b0, 1'b0, 1'b0);
  endtask

  // status stays sticky while masked; read clears it
  task automatic t_irq();
    expect_reg(OFS_IRQ_STAT, 32'h3);
    i_hae_host.bus_write(OFS_IRQ_MASK, 32'h1);
    expect_reg(OFS_IRQ_MASK, 32'h1);
    tk(16'h001F, 16'h0, 16'h0, 16'h0, FS);
    chk_out(1'b1, 1'b0, 1'b1);
    expect_reg(OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk_out(1'b1, 1'b0, 1'b0);
    expect_reg(OFS_IRQ_STAT, 32'h0);
    cancel();
  endtask

  task automatic t_burn();
    tk(16'h0, 16'h0, 16'h018F, 16'h000A, 6'h0C);
    expect_reg(OFS_ALARM, 32'h0);
    tk(16'h0, 16'h0, 16'h0190, 16'h000B, 6'h0C);
    expect_reg(OFS_ALARM, 32'h0);
    tk(16'h0, 16'h0, 16'h0190, 16'h000A, 6'h1C);
    expect_reg(OFS_ALARM, 32'h0);
    tk(16'h0, 16'h0, 16'h0190, 16'h000A, 6'h2C);
    expect_reg(OFS_ALARM, 32'h0);
    tk(16'h0, 16'h0, 16'h0190, 16'h000A, 6'h0C);
    expect_reg(OFS_ALARM, 32'h8);
    chk_out(1'b0, 1'b1, 1'b0);
    cancel();
  endtask

  // fresh history, three samples of 1000 then a jump to 1300 (30 %)
  task automatic run_lr(input logic [5:0] f0, f1, f2, f3,
                        input logic [31:0] exp);
    do_reset();
    tk(16'h0, 16'h03E8, 16'h0, 16'h0, f0);
    tk(16'h0, 16'h03E8, 16'h0, 16'h0, f1);
    tk(16'h0, 16'h03E8, 16'h0, 16'h0, f2);
    expect_reg(OFS_ALARM, 32'h0);
    tk(16'h0, 16'h0514, 16'h0, 16'h0, f3);
    expect_reg(OFS_ALARM, exp);
  endtask

  task automatic t_last();
    run_lr(FS, FS, FS, FW, 32'h4);
    expect_reg(fa(0, FLD_LAST_RATE), 32'h0000_012C);
    chk_out(1'b1, 1'b0, 1'b0);
    run_lr(FS, FS, 6'h05, FS, 32'h0);
    run_lr(FW, FW, FW, FS, 32'h0);
    run_lr(FS, FS, FS, 6'h0C, 32'h0);
  endtask

  initial begin
    do_reset();
    t_regs();
    t_det();
    t_irq();
    t_burn();
    t_last();
    complete_run();
  end
endmodule
`default_nettype wire
